/* verif/mms_host_model.sv */
/*
  Host controller model on the two-wire management bus, on its own link clock.
  Assumes a pull-up on SDA: the wire is the AND of all open-drain drivers.
*/
module mms_host_model #(
  parameter int HALF = 100
) (
  input wire logic lclk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int QTR = HALF / 3;
  // the bus clock stands high between frames, which is its pulled-up level
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // every step but the stop ends a while after a falling clock, so data never moves beside it
  task automatic hold(input logic c, input logic s, input int n);
    scl <= c;
    sda_drv <= s;
    repeat (n) @(posedge lclk);
  endtask : hold
  task automatic put_bit(input logic b);
    hold(1'b0, b, HALF);
    hold(1'b1, b, HALF);
    hold(1'b0, b, QTR);
  endtask : put_bit
  // sample in mid high phase; the device drives only after a fall
  task automatic get_bit(output logic b);
    hold(1'b0, 1'b1, HALF);
    hold(1'b1, 1'b1, HALF / 2);
    b = sda_wire;
    hold(1'b1, 1'b1, HALF / 2);
    hold(1'b0, 1'b1, QTR);
  endtask : get_bit
  // also serves as repeated start after an acknowledge
  task automatic bus_start;
    hold(scl, 1'b1, HALF);
    hold(1'b1, 1'b1, HALF);
    hold(1'b1, 1'b0, HALF);
    hold(1'b0, 1'b0, QTR);
  endtask : bus_start
  task automatic bus_stop;
    hold(1'b0, 1'b0, HALF);
    hold(1'b1, 1'b0, HALF);
    hold(1'b1, 1'b1, HALF);
  endtask : bus_stop
  // bytes go most significant bit first
  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i]);
    end
    get_bit(b);
    ack = !b;
  endtask : send_byte
  task automatic recv_byte(input logic last, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      get_bit(v[i]);
    end
    put_bit(last);
  endtask : recv_byte
endmodule : mms_host_model

/* verif/mms_mgmt_assertions.sv */
/*
  Checker of the management block's pin timing, bound into mms_mgmt.
  Assumes CLK at 10 MHz, so 1000 cycles stand for 100 us.
*/
module mms_mgmt_checker #(
  parameter int INIT_CYC = 50
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic MODULE_RESET_N,
  input wire logic LOW_POWER_SELECT,
  input wire logic MODULE_SELECT_N,
  input wire logic SDA_OE,
  input wire logic INTERRUPT_OUT_N,
  input wire logic LOW_POWER,
  input wire logic BUS_ACTIVE,
  input wire logic DATA_NOT_READY
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  logic [31:0] wait_r;
  logic [31:0] wait_nxt;
  // cycles spent not ready; the pin reset and low power restart the count
  always_comb begin
    wait_nxt = 32'h00000000;
    if (DATA_NOT_READY && MODULE_RESET_N && !LOW_POWER) begin
      wait_nxt = wait_r + 32'h00000001;
    end
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wait_r <= 32'h00000000;
    end else begin
      wait_r <= wait_nxt;
    end
  end
  chk_reset_state: assert property (
    $rose(RST_N) |-> DATA_NOT_READY && INTERRUPT_OUT_N && !BUS_ACTIVE && !LOW_POWER)
    else $error("state wrong after reset");
  chk_init_bound: assert property (wait_r <= INIT_CYC + 40)
    else $error("init took too long");
  chk_pin_reset: assert property (
    $rose(DATA_NOT_READY) && !LOW_POWER |-> !$past(MODULE_RESET_N, 8))
    else $error("reset taken from a short pulse");
  chk_ready_irq: assert property ($fell(DATA_NOT_READY) |-> ##[0:4] !INTERRUPT_OUT_N)
    else $error("no interrupt at ready");
  chk_lp_pin: assert property (
    $rose(LOW_POWER_SELECT) && MODULE_RESET_N |-> ##[1:1000] LOW_POWER)
    else $error("low power pin late");
  chk_sel_on: assert property (
    $fell(MODULE_SELECT_N) && !DATA_NOT_READY |-> ##[1:1000] BUS_ACTIVE)
    else $error("bus not enabled by select");
  chk_sel_off: assert property ($rose(MODULE_SELECT_N) |-> ##[1:1000] !BUS_ACTIVE)
    else $error("bus still enabled");
  chk_quiet_bus: assert property ((!BUS_ACTIVE) [*3] |-> !SDA_OE)
    else $error("data driven while bus off");
  chk_irq_release: assert property (
    $rose(INTERRUPT_OUT_N) |-> BUS_ACTIVE || DATA_NOT_READY || $past(BUS_ACTIVE, 4))
    else $error("interrupt released without access");
  cover property ($fell(INTERRUPT_OUT_N) && !DATA_NOT_READY);
  cover property ($rose(LOW_POWER));
  cover property ($rose(DATA_NOT_READY));
endmodule : mms_mgmt_checker

bind mms_mgmt mms_mgmt_checker #(.INIT_CYC(INIT_CYC)) u_mms_chk (
  .CLK(CLK), .RST_N(RST_N), .MODULE_RESET_N(MODULE_RESET_N),
  .LOW_POWER_SELECT(LOW_POWER_SELECT), .MODULE_SELECT_N(MODULE_SELECT_N),
  .SDA_OE(SDA_OE), .INTERRUPT_OUT_N(INTERRUPT_OUT_N), .LOW_POWER(LOW_POWER),
  .BUS_ACTIVE(BUS_ACTIVE), .DATA_NOT_READY(DATA_NOT_READY)
);

/* verif/testbench.sv */
/*
  Self-checking bench of the management block driven through a host model.
  Assumes the design, the host model and the checker are compiled first.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int INIT_CYC = 50;
  logic CLK, RST_N, MODULE_RESET_N, LOW_POWER_SELECT, MODULE_SELECT_N;
  logic [3:0] RX_LOS, TX_FAULT;
  logic [7:0] MODULE_ALARM, d;
  logic SDA_OUT, SDA_OE, INTERRUPT_OUT_N, LOW_POWER, BUS_ACTIVE, DATA_NOT_READY, a;
  logic lclk, scl, sda_drv, sda_wire;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  // open-drain data line with a pull-up: low when either side pulls
  assign sda_wire = sda_drv & ~(SDA_OE & ~SDA_OUT);
  mms_mgmt #(.INIT_CYC(INIT_CYC)) u_dut (
    .CLK(CLK), .RST_N(RST_N), .MODULE_RESET_N(MODULE_RESET_N),
    .LOW_POWER_SELECT(LOW_POWER_SELECT), .MODULE_SELECT_N(MODULE_SELECT_N),
    .SCL(scl), .SDA_IN(sda_wire), .RX_LOS(RX_LOS), .TX_FAULT(TX_FAULT),
    .MODULE_ALARM(MODULE_ALARM), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .INTERRUPT_OUT_N(INTERRUPT_OUT_N), .LOW_POWER(LOW_POWER), .BUS_ACTIVE(BUS_ACTIVE),
    .DATA_NOT_READY(DATA_NOT_READY)
  );
  mms_host_model u_host (.lclk(lclk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));
  // 100 ns housekeeping clock; 15 ns link clock at an unrelated offset
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  initial begin
    lclk = 1'b0;
    #3.3;
    forever #7.5 lclk = ~lclk;
  end
  // a hang is cut short well beyond the expected run length
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 80000) begin
      n_mismatch++;
      $display("mismatch at %0t: run timed out", $time);
      results();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : step
  // sel: 0 interrupt, 1 not ready, 2 low power, 3 bus active; bounded wait
  task automatic wait_for(input int sel, input logic val, input int lim, input string what);
    logic s;
    int n;
    n = 0;
    s = ~val;
    while (s !== val && n < lim) begin
      step(1);
      s = sel == 0 ? INTERRUPT_OUT_N : sel == 1 ? DATA_NOT_READY : sel == 2 ? LOW_POWER
          : BUS_ACTIVE;
      n++;
    end
    check({7'h00, s}, {7'h00, val}, what);
  endtask : wait_for
  task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
    logic a0, a1, a2;
    u_host.bus_start();
    u_host.send_byte(8'hA0, a0);
    u_host.send_byte(ofs, a1);
    u_host.send_byte(v, a2);
    u_host.bus_stop();
    check({5'h00, a0, a1, a2}, 8'h07, "write acks");
  endtask : wr
  task automatic rd(input logic [7:0] ofs, output logic [7:0] v);
    logic a0, a1, a2;
    u_host.bus_start();
    u_host.send_byte(8'hA0, a0);
    u_host.send_byte(ofs, a1);
    u_host.bus_start();
    u_host.send_byte(8'hA1, a2);
    u_host.recv_byte(1'b1, v);
    u_host.bus_stop();
    check({5'h00, a0, a1, a2}, 8'h07, "read acks");
  endtask : rd
  task automatic probe(input logic [7:0] adr, output logic ack);
    u_host.bus_start();
    u_host.send_byte(adr, ack);
    u_host.bus_stop();
  endtask : probe
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  // main sequence: each step is a bus access or a pin change and its expectation
  initial begin
    RST_N = 1'b0;
    MODULE_RESET_N = 1'b1;
    LOW_POWER_SELECT = 1'b0;
    MODULE_SELECT_N = 1'b1;
    RX_LOS = 4'h0;
    TX_FAULT = 4'h0;
    MODULE_ALARM = 8'h00;
    step(20);
    RST_N = 1'b1;
    step(1);
    check({4'h0, DATA_NOT_READY, INTERRUPT_OUT_N, BUS_ACTIVE, LOW_POWER}, 8'h0C, "reset");
    wait_for(1, 1'b0, INIT_CYC + 40, "init");
    // the interrupt follows the status bit by one registered stage
    wait_for(0, 1'b0, 4, "ready irq");
    MODULE_SELECT_N = 1'b0;
    wait_for(3, 1'b1, 1000, "select on");
    rd(8'h02, d);
    check(d & 8'h01, 8'h00, "status bit");
    wait_for(0, 1'b1, 5000, "ready irq release");
    probe(8'h42, a);
    check({7'h00, a}, 8'h00, "foreign address");
    for (int i = 0; i < 3; i++) begin
      RX_LOS = i == 0 ? 4'h4 : 4'h0;
      TX_FAULT = i == 1 ? 4'h1 : 4'h0;
      MODULE_ALARM = i == 2 ? 8'h80 : 8'h00;
      step(30);
      RX_LOS = 4'h0;
      TX_FAULT = 4'h0;
      MODULE_ALARM = 8'h00;
      wait_for(0, 1'b0, 100, "flag irq");
      rd(i == 0 ? 8'h03 : i == 1 ? 8'h04 : 8'h06, d);
      check(d, i == 0 ? 8'h04 : i == 1 ? 8'h01 : 8'h80, "latched flag");
      wait_for(0, 1'b1, 5000, "flag irq release");
      rd(i == 0 ? 8'h03 : i == 1 ? 8'h04 : 8'h06, d);
      check(d, 8'h00, "flag cleared");
    end
    wr(8'h64, 8'h0F);
    RX_LOS = 4'h2;
    step(30);
    RX_LOS = 4'h0;
    step(200);
    check({7'h00, INTERRUPT_OUT_N}, 8'h01, "masked flag");
    rd(8'h64, d);
    check(d, 8'h0F, "mask readback");
    wr(8'h64, 8'h00);
    wait_for(0, 1'b0, 1000, "unmasked flag");
    rd(8'h03, d);
    check(d, 8'h02, "flag under mask");
    wr(8'h5D, 8'h02);
    wait_for(2, 1'b1, 1000, "power down");
    wr(8'h5D, 8'h00);
    wait_for(2, 1'b0, 3000, "power up");
    LOW_POWER_SELECT = 1'b1;
    wait_for(2, 1'b1, 1000, "low power pin");
    LOW_POWER_SELECT = 1'b0;
    wait_for(2, 1'b0, 3000, "low power pin off");
    for (int i = 0; i < 2; i++) begin
      wr(8'h7F, i == 0 ? 8'h02 : 8'h00);
      wr(i == 0 ? 8'h80 : 8'hE0, i == 0 ? 8'hA5 : 8'h5A);
      rd(i == 0 ? 8'h80 : 8'hE0, d);
      check(d, i == 0 ? 8'hA5 : 8'h5A, "stored byte");
    end
    MODULE_SELECT_N = 1'b1;
    wait_for(3, 1'b0, 1000, "select off");
    probe(8'hA0, a);
    check({7'h00, a}, 8'h00, "deselected");
    MODULE_RESET_N = 1'b0;
    step(15);
    MODULE_RESET_N = 1'b1;
    step(50);
    check({7'h00, DATA_NOT_READY}, 8'h00, "short reset pulse");
    MODULE_RESET_N = 1'b0;
    step(50);
    check({7'h00, DATA_NOT_READY}, 8'h01, "long reset pulse");
    MODULE_RESET_N = 1'b1;
    wait_for(1, 1'b0, INIT_CYC + 40, "reinit");
    wait_for(0, 1'b0, 4, "reinit irq");
    results();
  end
endmodule : testbench

/* verilog/mms_defines.svh */
/*
  Constants of the module management block: timing counts, bus address,
  byte offsets, field positions and reset values.
  Assumes a 10 MHz housekeeping clock; included by its bare name.
*/
`ifndef MMS_DEFINES_SVH
`define MMS_DEFINES_SVH

// clock rate and documented times
`define MMS_CLK_HZ 10000000
`define MMS_T_INIT_MS 2000
`define MMS_INIT_CYC (`MMS_T_INIT_MS * (`MMS_CLK_HZ / 1000))
`define MMS_T_RST_MIN_US 2
`define MMS_RST_CYC ((`MMS_T_RST_MIN_US * `MMS_CLK_HZ + 999999) / 1000000)

// input filtering, in clock cycles
`define MMS_PIN_FILT_CYC 4
`define MMS_BUS_FILT_CYC 2

// two-wire bus device address, seven bits
`define MMS_DEV_ADDR 7'h50

// lower page byte offsets
`define MMS_OFS_STATUS 8'h02
`define MMS_OFS_LOS_FLAG 8'h03
`define MMS_OFS_TXF_FLAG 8'h04
`define MMS_OFS_ALM_FLAG 8'h06
`define MMS_OFS_CTRL 8'h5D
`define MMS_OFS_LOS_MASK 8'h64
`define MMS_OFS_TXF_MASK 8'h65
`define MMS_OFS_ALM_MASK 8'h67
`define MMS_OFS_PAGE 8'h7F

// upper page layout
`define MMS_OFS_VENDOR 8'hE0
`define MMS_PAGE_BASE 8'h00
`define MMS_PAGE_USER 8'h02

// fields and reset values
`define MMS_CTRL_PDOWN_BIT 1
`define MMS_CTRL_RST 8'h00
`define MMS_MASK4_RST 4'h0
`define MMS_MASK8_RST 8'h00

`endif

/* verilog/mms_mem.sv */
/*
  Byte store for the user page and the vendor area, registered read data.
  Assumes one access per cycle; a write also reads the written address.
*/
module mms_mem #(
  parameter int AW = 8
) (
  input wire logic clk,
  mms_mem_if.mem port
);

  logic [7:0] store [0:(1<<AW)-1];
  logic [7:0] rdata_r;

  // contents are opaque bytes; nothing here interprets them
  always_ff @(posedge clk) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
    rdata_r <= store[port.addr];
  end

  assign port.rdata = rdata_r;

endmodule : mms_mem

/* verilog/mms_mem_if.sv */
/*
  Carrier between the management logic and its nonvolatile store.
  Assumes a single clock shared by both ends.
*/
interface mms_mem_if #(parameter int AW = 8);
  logic [AW-1:0] addr;
  logic we;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport ctl (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface : mms_mem_if

/* verilog/mms_mgmt.sv */
/*
  Management control and status sequencing of a four-lane pluggable module:
  reset and init timing, data-not-ready status, sticky flags with masks,
  the active-low interrupt, low-power control and a two-wire bus slave.
  Assumes CLK at 10 MHz; all pins are asynchronous; all but RST_N are synchronised and
  filtered here. SCL and SDA are oversampled, so bus rates up to 400 kHz.
*/
// Behaviour
// - fully functional within 2000 ms after start
// - reset only when input low over 2 us
// - answer bus within 2000 ms of power
// - clear data-not-ready and assert interrupt at init
// - functional within 2000 ms after reset rise
// - low-power select enters low power quickly
// - interrupt driven low within 200 ms
// - flags clear on read, interrupt then released
// - loss-of-signal sets flag and interrupt quickly
// - transmit fault sets flag and interrupt quickly
// - other conditions set flag and interrupt
// - set mask stops flag driving interrupt
// - cleared mask lets flag drive interrupt
// - select asserted enables bus answers
// - select released stops bus answers
// - power-down bit set enters low power
// - power-down bit cleared returns to full power
// - functional means interrupt from data-not-ready clear
// - read delays count from the read's end
// - write delays count from the write's end
// - user page stored, never interpreted
// - upper bytes 224 to 255 vendor area
// - answer on device address A0h
`include "mms_defines.svh"

module mms_mgmt #(
  parameter int INIT_CYC = `MMS_INIT_CYC,
  parameter logic [7:0] IDENT_BYTE = 8'h00 // arbitrary value
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic MODULE_RESET_N,
  input wire logic LOW_POWER_SELECT,
  input wire logic MODULE_SELECT_N,
  input wire logic SCL,
  input wire logic SDA_IN,
  input wire logic [3:0] RX_LOS,
  input wire logic [3:0] TX_FAULT,
  input wire logic [7:0] MODULE_ALARM,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic INTERRUPT_OUT_N,
  output logic LOW_POWER,
  output logic BUS_ACTIVE,
  output logic DATA_NOT_READY
);

  mms_pkg::mms_state_t q_r;
  mms_pkg::mms_state_t q_nxt;

  logic [2:0] pins_s;
  logic [1:0] bus_s;
  logic [15:0] cond_s;
  logic module_reset_n_s;
  logic low_power_select_s;
  logic module_select_n_s;
  logic scl_s;
  logic sda_s;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic bus_en;
  logic reset_hit;
  logic [7:0] rd_byte;
  logic in_mem;
  logic [7:0] mem_idx;

  mms_mem_if #(.AW(8)) mem_bus ();

  // control pins, idle levels high for the active-low ones
  mms_sync #(.W(3), .FILT(`MMS_PIN_FILT_CYC), .INIT(3'h5)) u_pin_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .d({MODULE_RESET_N, LOW_POWER_SELECT, MODULE_SELECT_N}),
    .q(pins_s)
  );

  // bus lines get a shorter filter so fast-mode edges still pass
  mms_sync #(.W(2), .FILT(`MMS_BUS_FILT_CYC), .INIT(2'h3)) u_bus_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .d({SCL, SDA_IN}),
    .q(bus_s)
  );

  // optical and housekeeping conditions come from other domains too
  mms_sync #(.W(16), .FILT(`MMS_PIN_FILT_CYC), .INIT(16'h0000)) u_cond_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .d({MODULE_ALARM, TX_FAULT, RX_LOS}),
    .q(cond_s)
  );

  mms_mem #(.AW(8)) u_mem (
    .clk(CLK),
    .port(mem_bus.mem)
  );

  assign module_reset_n_s = pins_s[2];
  assign low_power_select_s = pins_s[1];
  assign module_select_n_s = pins_s[0];
  assign scl_s = bus_s[1];
  assign sda_s = bus_s[0];

  // bus events seen on the filtered lines
  assign rise = scl_s & ~q_r.scl_p;
  assign fall = ~scl_s & q_r.scl_p;
  assign start = scl_s & q_r.scl_p & ~sda_s & q_r.sda_p;
  assign stop = scl_s & q_r.scl_p & sda_s & ~q_r.sda_p;

  // answers only when running and selected
  assign bus_en = (q_r.mode == mms_pkg::MODE_RUN) & ~module_select_n_s;

  // a reset counts only once the pin has stayed low past the minimum
  assign reset_hit = ~module_reset_n_s & (q_r.rst_cnt == 8'(`MMS_RST_CYC));

  // upper page windows backed by the store
  assign in_mem = q_r.ptr[7] & ((q_r.page == `MMS_PAGE_USER) |
                  ((q_r.page == `MMS_PAGE_BASE) && (q_r.ptr >= `MMS_OFS_VENDOR)));
  assign mem_idx = {q_r.page == `MMS_PAGE_USER, q_r.ptr[6:0]};

  // store port: a pending write takes the address, reads follow the pointer
  assign mem_bus.addr = q_r.mem_we ? q_r.mem_wa : mem_idx;
  assign mem_bus.we = q_r.mem_we;
  assign mem_bus.wdata = q_r.mem_wd;

  // byte returned for the current pointer
  always_comb begin
    rd_byte = 8'h00;
    if (in_mem) begin
      rd_byte = mem_bus.rdata;
    end else begin
      case (q_r.ptr)
        8'h00: rd_byte = IDENT_BYTE;
        `MMS_OFS_STATUS: rd_byte = {7'h00, q_r.dnr};
        `MMS_OFS_LOS_FLAG: rd_byte = {4'h0, q_r.los_flag};
        `MMS_OFS_TXF_FLAG: rd_byte = {4'h0, q_r.txf_flag};
        `MMS_OFS_ALM_FLAG: rd_byte = q_r.alm_flag;
        `MMS_OFS_CTRL: rd_byte = q_r.ctrl;
        `MMS_OFS_LOS_MASK: rd_byte = {4'h0, q_r.los_mask};
        `MMS_OFS_TXF_MASK: rd_byte = {4'h0, q_r.txf_mask};
        `MMS_OFS_ALM_MASK: rd_byte = q_r.alm_mask;
        `MMS_OFS_PAGE: rd_byte = q_r.page;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // next state of the whole block
  always_comb begin
    logic ld;
    logic wr;
    ld = 1'b0;
    wr = 1'b0;
    q_nxt = q_r;
    q_nxt.mem_we = 1'b0;
    q_nxt.scl_p = scl_s;
    q_nxt.sda_p = sda_s;

    // reset pin low-time counter, saturating at the minimum
    if (module_reset_n_s) begin
      q_nxt.rst_cnt = 8'h00;
    end else if (q_r.rst_cnt != 8'(`MMS_RST_CYC)) begin
      q_nxt.rst_cnt = q_r.rst_cnt + 8'h01;
    end

    // power-up and reset sequencing
    case (q_r.mode)
      mms_pkg::MODE_INIT: begin
        q_nxt.init_cnt = q_r.init_cnt + 32'h0000_0001;
        if (q_r.init_cnt == 32'(INIT_CYC - 1)) begin
          q_nxt.mode = mms_pkg::MODE_RUN;
          q_nxt.dnr = 1'b0;
          q_nxt.ready_flag = 1'b1;
        end
      end
      mms_pkg::MODE_RUN: begin
        q_nxt.init_cnt = 32'h0000_0000;
      end
      mms_pkg::MODE_HELD: begin
        // leave on the rising edge of the reset pin
        if (module_reset_n_s) begin
          q_nxt.mode = mms_pkg::MODE_INIT;
          q_nxt.init_cnt = 32'h0000_0000;
        end
      end
      default: begin
        q_nxt.mode = mms_pkg::MODE_INIT;
      end
    endcase

    // two-wire slave; start and stop win over bit activity
    if (!bus_en || stop) begin
      q_nxt.bus = mms_pkg::BUS_IDLE;
      q_nxt.sda_oe = 1'b0;
    end else if (start) begin
      q_nxt.bus = mms_pkg::BUS_ADDR;
      q_nxt.bitc = 4'h0;
      q_nxt.sda_oe = 1'b0;
    end else begin
      case (q_r.bus)
        mms_pkg::BUS_IDLE: begin
          q_nxt.sda_oe = 1'b0;
        end
        mms_pkg::BUS_ADDR, mms_pkg::BUS_RX: begin
          if (rise) begin
            q_nxt.shreg = {q_r.shreg[6:0], sda_s};
            q_nxt.bitc = q_r.bitc + 4'h1;
          end else if (fall && q_r.bitc == 4'h8) begin
            if (q_r.bus == mms_pkg::BUS_RX) begin
              q_nxt.bus = mms_pkg::BUS_ACK_W;
              q_nxt.sda_oe = 1'b1;
              wr = 1'b1;
            end else if (q_r.shreg[7:1] == `MMS_DEV_ADDR) begin
              q_nxt.bus = mms_pkg::BUS_ACK_A;
              q_nxt.rw = q_r.shreg[0];
              q_nxt.sda_oe = 1'b1;
            end else begin
              q_nxt.bus = mms_pkg::BUS_IDLE;
            end
          end
        end
        mms_pkg::BUS_ACK_A: begin
          if (fall) begin
            q_nxt.bitc = 4'h0;
            if (q_r.rw) begin
              q_nxt.bus = mms_pkg::BUS_TX;
              ld = 1'b1;
            end else begin
              q_nxt.bus = mms_pkg::BUS_RX;
              q_nxt.first = 1'b1;
              q_nxt.sda_oe = 1'b0;
            end
          end
        end
        mms_pkg::BUS_ACK_W: begin
          if (fall) begin
            q_nxt.bus = mms_pkg::BUS_RX;
            q_nxt.bitc = 4'h0;
            q_nxt.sda_oe = 1'b0;
          end
        end
        mms_pkg::BUS_TX: begin
          if (fall) begin
            if (q_r.bitc == 4'h7) begin
              q_nxt.bus = mms_pkg::BUS_MACK;
              q_nxt.sda_oe = 1'b0;
            end else begin
              q_nxt.shreg = {q_r.shreg[6:0], 1'b0};
              q_nxt.sda_oe = ~q_r.shreg[6];
              q_nxt.bitc = q_r.bitc + 4'h1;
            end
          end
        end
        mms_pkg::BUS_MACK: begin
          // host ack is kept in bit 0; a nack ends the read
          if (rise) begin
            q_nxt.shreg[0] = sda_s;
          end else if (fall) begin
            if (q_r.shreg[0]) begin
              q_nxt.bus = mms_pkg::BUS_IDLE;
            end else begin
              q_nxt.bus = mms_pkg::BUS_TX;
              q_nxt.bitc = 4'h0;
              ld = 1'b1;
            end
          end
        end
        default: begin
          q_nxt.bus = mms_pkg::BUS_IDLE;
          q_nxt.sda_oe = 1'b0;
        end
      endcase
    end

    // load a byte for the host; flag bytes clear as they are read
    if (ld) begin
      q_nxt.shreg = rd_byte;
      q_nxt.sda_oe = ~rd_byte[7];
      q_nxt.ptr = q_r.ptr + 8'h01;
      case (q_r.ptr)
        `MMS_OFS_STATUS: q_nxt.ready_flag = 1'b0;
        `MMS_OFS_LOS_FLAG: q_nxt.los_flag = 4'h0;
        `MMS_OFS_TXF_FLAG: q_nxt.txf_flag = 4'h0;
        `MMS_OFS_ALM_FLAG: q_nxt.alm_flag = 8'h00;
        default: q_nxt.ptr = q_r.ptr + 8'h01;
      endcase
    end

    // first written byte is the pointer, later ones land at it
    if (wr) begin
      if (q_r.first) begin
        q_nxt.first = 1'b0;
        q_nxt.ptr = q_r.shreg;
      end else begin
        q_nxt.ptr = q_r.ptr + 8'h01;
        if (in_mem) begin
          q_nxt.mem_we = 1'b1;
          q_nxt.mem_wa = mem_idx;
          q_nxt.mem_wd = q_r.shreg;
        end
        case (q_r.ptr)
          `MMS_OFS_CTRL: q_nxt.ctrl = q_r.shreg;
          `MMS_OFS_LOS_MASK: q_nxt.los_mask = q_r.shreg[3:0];
          `MMS_OFS_TXF_MASK: q_nxt.txf_mask = q_r.shreg[3:0];
          `MMS_OFS_ALM_MASK: q_nxt.alm_mask = q_r.shreg;
          `MMS_OFS_PAGE: q_nxt.page = q_r.shreg;
          default: q_nxt.page = q_nxt.page;
        endcase
      end
    end

    // sticky flags: applied after the read clear so a new event wins
    q_nxt.los_flag = q_nxt.los_flag | cond_s[3:0];
    q_nxt.txf_flag = q_nxt.txf_flag | cond_s[7:4];
    q_nxt.alm_flag = q_nxt.alm_flag | cond_s[15:8];

    // a recognised reset pulse wipes status and control
    if (reset_hit || q_r.mode == mms_pkg::MODE_HELD) begin
      if (reset_hit) begin
        q_nxt.mode = mms_pkg::MODE_HELD;
      end
      q_nxt.dnr = 1'b1;
      q_nxt.ready_flag = 1'b0;
      q_nxt.los_flag = 4'h0;
      q_nxt.txf_flag = 4'h0;
      q_nxt.alm_flag = 8'h00;
      q_nxt.los_mask = `MMS_MASK4_RST;
      q_nxt.txf_mask = `MMS_MASK4_RST;
      q_nxt.alm_mask = `MMS_MASK8_RST;
      q_nxt.ctrl = `MMS_CTRL_RST;
      q_nxt.page = `MMS_PAGE_BASE;
      q_nxt.mem_we = 1'b0;
      q_nxt.bus = mms_pkg::BUS_IDLE;
      q_nxt.sda_oe = 1'b0;
    end

    // interrupt from unmasked flags; one cycle after the flags settle
    q_nxt.irq_n = ~(q_r.ready_flag |
                   (|(q_r.los_flag & ~q_r.los_mask)) |
                   (|(q_r.txf_flag & ~q_r.txf_mask)) |
                   (|(q_r.alm_flag & ~q_r.alm_mask)));
    q_nxt.low_power = low_power_select_s | q_r.ctrl[`MMS_CTRL_PDOWN_BIT];
    q_nxt.bus_active = bus_en;
  end

  // all state in one register; nothing here samples a port under reset
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      q_r <= '0;
      q_r.mode <= mms_pkg::MODE_INIT;
      q_r.bus <= mms_pkg::BUS_IDLE;
      q_r.scl_p <= 1'b1;
      q_r.sda_p <= 1'b1;
      q_r.dnr <= 1'b1;
      q_r.irq_n <= 1'b1;
      q_r.los_mask <= `MMS_MASK4_RST;
      q_r.txf_mask <= `MMS_MASK4_RST;
      q_r.alm_mask <= `MMS_MASK8_RST;
      q_r.ctrl <= `MMS_CTRL_RST;
      q_r.page <= `MMS_PAGE_BASE;
    end else begin
      q_r <= q_nxt;
    end
  end

  // open-drain data: only ever pulled low
  assign SDA_OUT = 1'b0;
  assign SDA_OE = q_r.sda_oe;
  assign INTERRUPT_OUT_N = q_r.irq_n;
  assign LOW_POWER = q_r.low_power;
  assign BUS_ACTIVE = q_r.bus_active;
  assign DATA_NOT_READY = q_r.dnr;

endmodule : mms_mgmt

/* verilog/mms_pkg.sv */
/*
  Types of the module management block: modes, bus states, state record.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mms_pkg;

  typedef enum logic [1:0] {MODE_INIT, MODE_RUN, MODE_HELD} mms_mode_t;

  typedef enum logic [2:0] {
    BUS_IDLE, BUS_ADDR, BUS_ACK_A, BUS_RX, BUS_ACK_W, BUS_TX, BUS_MACK
  } mms_bus_t;

  typedef struct packed {
    mms_mode_t mode;
    logic [31:0] init_cnt;
    logic [7:0] rst_cnt;
    mms_bus_t bus;
    logic [3:0] bitc;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic rw;
    logic first;
    logic scl_p;
    logic sda_p;
    logic dnr;
    logic ready_flag;
    logic [3:0] los_flag;
    logic [3:0] txf_flag;
    logic [7:0] alm_flag;
    logic [3:0] los_mask;
    logic [3:0] txf_mask;
    logic [7:0] alm_mask;
    logic [7:0] ctrl;
    logic [7:0] page;
    logic mem_we;
    logic [7:0] mem_wa;
    logic [7:0] mem_wd;
    logic irq_n;
    logic low_power;
    logic bus_active;
    logic sda_oe;
  } mms_state_t;

endpackage : mms_pkg

/* verilog/mms_sync.sv */
/*
  Two-flop synchroniser with a stability filter for a group of pins.
  Assumes the pins are asynchronous to clk; output follows after FILT + 2
  stable cycles, so narrow glitches never reach the logic.
*/
module mms_sync #(
  parameter int W = 1,
  parameter int FILT = 2,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] cand;
    logic [W-1:0] outv;
    logic [7:0] cnt;
  } mms_sync_st_t;

  mms_sync_st_t r_r;
  mms_sync_st_t r_nxt;

  // s1 feeds s2 only; the filter looks at s2 and later
  always_comb begin
    r_nxt = r_r;
    r_nxt.s1 = d;
    r_nxt.s2 = r_r.s1;
    r_nxt.cand = r_r.s2;
    if (r_r.s2 != r_r.cand) begin
      r_nxt.cnt = 8'h00;
    end else if (r_r.cnt < 8'(FILT)) begin
      r_nxt.cnt = r_r.cnt + 8'h01;
    end else begin
      r_nxt.outv = r_r.s2;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= '{s1: INIT, s2: INIT, cand: INIT, outv: INIT, cnt: 8'h00};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign q = r_r.outv;

endmodule : mms_sync
